//--- sim/acc_adc_sva.sv
// Port assertions for the converter control
`timescale 1ns/1ps
module acc_adc_sva (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_addr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_irq_ack,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [7:0] o_channel_enable,
   input wire logic [2:0] o_channel_select,
   input wire logic o_core_start,
   input wire logic o_busy,
   input wire logic o_irq,
   input wire logic [7:0] o_irq_vector
);
   logic [10:0] busy_cnt_reg;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   always_ff @(posedge i_clk) begin
      busy_cnt_reg <= (i_rst || !o_busy) ? 11'h000 : busy_cnt_reg + 11'h001;
   end
   AST_VECTOR: assert property (o_irq_vector == 8'h53)
      else $error("wrong vector");
   AST_ENABLE: assert property (i_sfr_wr && i_sfr_addr == 8'hab |=>
      o_channel_enable == $past(i_sfr_wdata)) else $error("enable not written");
   // A start written in the closing cycle is lost to the end-of-conversion clear
   AST_START: assert property (i_sfr_wr && i_sfr_addr == 8'hac && i_sfr_wdata[7]
      && !o_busy && !$fell(o_busy) |-> ##2 o_core_start) else $error("no sample strobe");
   AST_PULSE: assert property (o_core_start |=> !o_core_start && o_busy)
      else $error("strobe not a pulse");
   AST_SELECT: assert property (i_sfr_wr && i_sfr_addr == 8'hac |=>
      o_channel_select == $past(i_sfr_wdata[2:0])) else $error("select wrong");
   AST_DURATION: assert property ($fell(o_busy) |-> busy_cnt_reg >= 11'd44)
      else $error("conversion too short");
   AST_IRQ_END: assert property ($fell(o_busy) |-> ##[0:2] o_irq)
      else $error("no request at end");
   // Set wins over an acknowledge in the closing cycle
   AST_IRQ_ACK: assert property (i_irq_ack && o_irq && !o_busy && !$past(o_busy) |=> !o_irq)
      else $error("request not cleared");
   AST_RDATA_IDLE: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
      else $error("read data not zero");
endmodule
bind acc_adc_control acc_adc_sva sva_i (.*);

//--- sim/acc_core_model.sv
// Converter core stand-in for the control block
`timescale 1ns/1ps
module acc_core_model (
   input wire logic i_clk, // system clock
   input wire logic i_start, // sample strobe
   input wire logic [2:0] i_channel, // selected input
   output logic [9:0] o_data // conversion result
);
   initial o_data = 10'h000;
   // Held until the next sample, so stable at the end
   always @(posedge i_clk) begin
      if (i_start) begin
         o_data <= 10'h2a5 ^ {i_channel, 7'h00};
      end
   end
endmodule

//--- sim/adc_conversion_control_test.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
module adc_conversion_control_test;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_sfr_wr = 1'b0;
   logic i_sfr_rd = 1'b0;
   logic [7:0] i_sfr_addr = 8'h00;
   logic [7:0] i_sfr_wdata = 8'h00;
   logic i_irq_ack = 1'b0;
   logic [9:0] core_data;
   logic [7:0] rdata;
   logic [7:0] chan_en;
   logic [2:0] chan_sel;
   logic core_start;
   logic busy;
   logic irq;
   logic [7:0] vector;
   int error_cnt = 0;
   int n_checks = 0;
   acc_adc_control uut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(i_sfr_wr),
      .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
      .i_core_data(core_data), .i_irq_ack(i_irq_ack), .o_sfr_rdata(rdata),
      .o_channel_enable(chan_en), .o_channel_select(chan_sel), .o_core_start(core_start),
      .o_busy(busy), .o_irq(irq), .o_irq_vector(vector));
   acc_core_model core (.i_clk(i_clk), .i_start(core_start), .i_channel(chan_sel),
      .o_data(core_data));
   initial forever #12.5 i_clk = ~i_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_sfr_wr <= 1'b1;
      i_sfr_addr <= a;
      i_sfr_wdata <= d;
      @(posedge i_clk);
      i_sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_sfr_rd <= 1'b1;
      i_sfr_addr <= a;
      @(posedge i_clk);
      i_sfr_rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic t_regs();
      for (int a = 8'hab; a <= 8'hb0; a++) begin
         rd(8'(a), 8'h00);
      end
      chk(vector, 8'h53);
      wr(8'hab, 8'ha5);
      #1 chk(chan_en, 8'ha5);
      rd(8'hab, 8'ha5);
      wr(8'haf, 8'hff);
      rd(8'haf, 8'h1f);
      wr(8'had, 8'hff);
      rd(8'had, 8'h00);
      wr(8'hac, 8'h47);
      rd(8'hac, 8'h47);
   endtask
   task automatic t_conv(input logic [2:0] ch, input logic al);
      logic [9:0] res;
      int lo;
      int n;
      res = 10'h2a5 ^ {ch, 7'h00};
      lo = 46 * (4 * ch + 2);
      n = 0;
      // divider of at least 1 keeps the converter clock legal
      wr(8'haf, {3'h0, ch, 2'h1});
      wr(8'hac, {1'b1, al, 3'h0, ch});
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk(8'(n >= lo && n <= lo + 4), 8'h01);
      rd(8'hac, {1'b0, al, 3'h0, ch});
      rd(8'had, al ? {6'h00, res[9:8]} : res[9:2]);
      rd(8'hae, al ? res[7:0] : {6'h00, res[1:0]});
      @(posedge i_clk);
      i_irq_ack <= 1'b1;
      @(posedge i_clk);
      i_irq_ack <= 1'b0;
      #1 chk({7'h00, irq}, 8'h00);
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      for (int c = 0; c < 8; c++) begin
         t_conv(3'(c), c[0]);
      end
      report_and_stop();
   end
endmodule

//--- src/acc_adc_control.sv
// Behaviour
// - Eight input channels, each result a 10-bit value in the result registers.
// - Interrupt requests are made on the vector at 53H.
// - Bit i of channel_enable enables channel i, and the register resets to zero.
// - Setting bit 7 of conversion_control starts a conversion on the selected channel.
// - Alignment 0 puts result 9..2 in result_high and result 1..0 in result_low 1..0.
// - Alignment 1 puts result 9..8 in result_high 1..0 and result 7..0 in result_low.
// - channel_select bits 2..0 pick channels 0 to 7 by binary value.
// - The converter clock is the system clock over 2*(divider+1).
// - A conversion lasts 23 converter clocks, 46 to 1472 system clocks.
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_adc_control #(
   parameter int RES_W = 10,
   parameter int CH_N = 8
) (
   input wire logic i_clk, // 40 MHz system clock
   input wire logic i_rst, // synchronous reset, active high
   input wire logic i_sfr_wr, // special function register write strobe
   input wire logic i_sfr_rd, // special function register read strobe
   input wire logic [7:0] i_sfr_addr, // direct address
   input wire logic [7:0] i_sfr_wdata, // write data
   input wire logic [RES_W-1:0] i_core_data, // converter core result
   input wire logic i_irq_ack, // interrupt taken by the controller
   output logic [7:0] o_sfr_rdata, // registered read data
   output logic [CH_N-1:0] o_channel_enable, // per-channel analog enables
   output logic [2:0] o_channel_select, // multiplexer select
   output logic o_core_start, // sample strobe to the core
   output logic o_busy, // conversion in progress
   output logic o_irq, // interrupt request level
   output logic [7:0] o_irq_vector // vector address of the request
);
   acc_pkg::acc_state_all_type s_reg;
   acc_pkg::acc_state_all_type s_next;
   logic tick;
   logic running;

   assign running = (s_reg.state == acc_pkg::ACC_SAMPLE);

   acc_clock_divider #(
      .DIV_W(5)
   ) u_div (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_run(running),
      .i_divider(s_reg.divider),
      .o_tick(tick)
   );

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.core_start = 1'b0;
      s_next.rdata = 8'h00;
      if (i_irq_ack) begin
         s_next.irq = 1'b0;
      end
      if (i_sfr_wr) begin
         if (hit(i_sfr_addr, `ACC_ADDR_CHANNEL_ENABLE)) begin
            s_next.channel_enable = i_sfr_wdata;
         end
         if (hit(i_sfr_addr, `ACC_ADDR_CONVERSION_CONTROL)) begin
            s_next.align = i_sfr_wdata[`ACC_BIT_ALIGN];
            s_next.channel_select = i_sfr_wdata[2:0];
            // Start cannot be cleared mid-conversion by software
            if (i_sfr_wdata[`ACC_BIT_START]) begin
               s_next.start = 1'b1;
            end
         end
         if (hit(i_sfr_addr, `ACC_ADDR_CLOCK_DIVIDER)) begin
            s_next.divider = i_sfr_wdata[4:0];
         end
      end
      if (i_sfr_rd) begin
         if (hit(i_sfr_addr, `ACC_ADDR_CHANNEL_ENABLE)) begin
            s_next.rdata = s_reg.channel_enable;
         end else if (hit(i_sfr_addr, `ACC_ADDR_CONVERSION_CONTROL)) begin
            s_next.rdata = {s_reg.start, s_reg.align, 3'h0, s_reg.channel_select};
         end else if (hit(i_sfr_addr, `ACC_ADDR_RESULT_HIGH)) begin
            s_next.rdata = s_reg.result_high;
         end else if (hit(i_sfr_addr, `ACC_ADDR_RESULT_LOW)) begin
            s_next.rdata = s_reg.result_low;
         end else if (hit(i_sfr_addr, `ACC_ADDR_CLOCK_DIVIDER)) begin
            s_next.rdata = {3'h0, s_reg.divider};
         end
      end
      unique case (s_reg.state)
         acc_pkg::ACC_IDLE: begin
            if (s_reg.start) begin
               s_next.state = acc_pkg::ACC_SAMPLE;
               s_next.clocks_left = `ACC_CONV_CLOCKS;
               s_next.core_start = 1'b1;
            end
         end
         acc_pkg::ACC_SAMPLE: begin
            if (tick) begin
               s_next.clocks_left = s_reg.clocks_left - 5'h01;
               if (s_reg.clocks_left == 5'h01) begin
                  s_next.state = acc_pkg::ACC_DONE;
               end
            end
         end
         acc_pkg::ACC_DONE: begin
            if (s_reg.align) begin
               s_next.result_high = {6'h00, i_core_data[9:8]};
               s_next.result_low = i_core_data[7:0];
            end else begin
               s_next.result_high = i_core_data[9:2];
               s_next.result_low = {6'h00, i_core_data[1:0]};
            end
            // finish: clear start, raise request; set wins over ack
            s_next.start = 1'b0;
            s_next.irq = 1'b1;
            s_next.state = acc_pkg::ACC_IDLE;
         end
         default: begin
            s_next.state = acc_pkg::ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_reg <= '0;
         s_reg.channel_enable <= `ACC_RST_CHANNEL_ENABLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_channel_enable = s_reg.channel_enable;
   assign o_channel_select = s_reg.channel_select;
   assign o_core_start = s_reg.core_start;
   assign o_busy = running;
   assign o_irq = s_reg.irq;
   assign o_sfr_rdata = s_reg.rdata;
   assign o_irq_vector = `ACC_INT_VECTOR;
endmodule

//--- src/acc_clock_divider.sv
// Converter clock divider: one tick every 2*(divider+1) system clocks
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_clock_divider #(
   parameter int DIV_W = 5
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst, // synchronous reset
   input wire logic i_run, // count while high
   input wire logic [DIV_W-1:0] i_divider, // clock select field
   output logic o_tick // one-cycle converter clock edge
);
   typedef struct packed {
      logic [DIV_W+1:0] count;
      logic tick;
   } acc_div_state_type;

   acc_div_state_type state_reg;
   acc_div_state_type state_next;
   logic [DIV_W+1:0] last;

   assign last = {1'b0, i_divider, 1'b1};

   always_comb begin
      state_next = state_reg;
      state_next.tick = 1'b0;
      if (!i_run) begin
         state_next.count = '0;
      end else if (state_reg.count == last) begin
         state_next.count = '0;
         state_next.tick = 1'b1;
      end else begin
         state_next.count = state_reg.count + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_tick = state_reg.tick;
endmodule

//--- src/acc_pkg.sv
// Types shared by the converter control modules
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_SAMPLE = 2'b01,
      ACC_DONE = 2'b11
   } acc_state_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acc_sfr_req_type;

   typedef struct packed {
      logic [7:0] channel_enable;
      logic start;
      logic align;
      logic [2:0] channel_select;
      logic [4:0] divider;
      logic [7:0] result_high;
      logic [7:0] result_low;
      logic [7:0] rdata;
      acc_state_type state;
      logic [4:0] clocks_left;
      logic irq;
      logic core_start;
   } acc_state_all_type;
endpackage

//--- src/acc_regs.svh
// Register map, field positions, reset values and timing counts of the converter control
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_ADDR_CHANNEL_ENABLE 8'hab
`define ACC_ADDR_CONVERSION_CONTROL 8'hac
`define ACC_ADDR_RESULT_HIGH 8'had
`define ACC_ADDR_RESULT_LOW 8'hae
`define ACC_ADDR_CLOCK_DIVIDER 8'haf
`define ACC_RST_CHANNEL_ENABLE 8'h00
`define ACC_RST_CONVERSION_CONTROL 8'h00
`define ACC_RST_RESULT 8'h00
`define ACC_RST_CLOCK_DIVIDER 8'h00
`define ACC_BIT_START 7
`define ACC_BIT_ALIGN 6
`define ACC_CTRL_MASK 8'hc7
`define ACC_DIV_MASK 8'h1f
`define ACC_CONV_CLOCKS 5'h17
`define ACC_INT_VECTOR 8'h53
`endif
